// *** bench/pcr_config_regs_asserts.sv ***
// ----------------------------------------
// Port checker for the config block
// ----------------------------------------
module pcr_config_regs_asserts (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       srst,
  // Control port
  input wire logic       cfg_wr_en,
  input wire logic       cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata_q,
  input wire logic       cfg_rvalid_q,
  // Stream and pins
  input wire logic       bitstream1_clock_pin_oe,
  input wire logic       play_valid,
  input wire logic       play_ready,
  input wire logic       play_overrun_q,
  // Controls out
  input wire logic [7:0] digital_volume_q,
  input wire logic       volume_mute_q,
  input wire logic       irq_pin_pullup_en_q,
  input wire logic       spread_spectrum_en_q,
  input wire logic       switching_sync_en_q,
  input wire logic [1:0] bitstream1_rate_q,
  input wire logic       bitstream1_rate_bad_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Write strobes per register
  sequence s_wr_misc; cfg_wr_en && cfg_addr == 8'h07; endsequence
  sequence s_wr_rate; cfg_wr_en && cfg_addr == 8'h08; endsequence
  sequence s_wr_clk;  cfg_wr_en && cfg_addr == 8'h09; endsequence
  chk_read_valid_pulse: assert property (cfg_rd_en |=> cfg_rvalid_q)
    else $error("read answer missing");
  chk_unmapped_read_zero: assert property (cfg_rd_en && (cfg_addr < 8'h06 || cfg_addr > 8'h09)
    |=> cfg_rdata_q == 8'h00) else $error("unmapped read not zero");
  chk_pullup_follows_write: assert property (s_wr_misc |-> ##2 irq_pin_pullup_en_q == $past(cfg_wdata[3], 2))
    else $error("pull-up enable wrong");
  chk_spread_follows_write: assert property (s_wr_misc |-> ##2 spread_spectrum_en_q == $past(cfg_wdata[2], 2))
    else $error("spread spectrum wrong");
  chk_sync_follows_write: assert property (s_wr_rate |-> ##2 switching_sync_en_q == $past(cfg_wdata[6], 2))
    else $error("switching sync wrong");
  chk_rate_field_flag: assert property (s_wr_rate |-> ##2 bitstream1_rate_q == $past(cfg_wdata[3:2], 2)
    && bitstream1_rate_bad_q == $past(cfg_wdata[3], 2)) else $error("rate field wrong");
  chk_clock_pin_drive: assert property (s_wr_clk |=> bitstream1_clock_pin_oe ==
    ($past(cfg_wdata[5]) && $past(cfg_wdata[3]))) else $error("clock pin drive wrong");
  chk_mute_from_code: assert property (volume_mute_q == (digital_volume_q >= 8'hC9))
    else $error("mute flag wrong");
  chk_overrun_sticky: assert property (play_overrun_q |=> play_overrun_q)
    else $error("overrun flag dropped");
  chk_word_held_stall: assert property (play_valid && !play_ready |=> play_valid)
    else $error("word lost while stalled");
endmodule

bind pcr_config_regs pcr_config_regs_asserts i_chk (.*);

// *** bench/pcr_config_regs_tb.sv ***
// ----------------------------------------
// Bench for the config block
// ----------------------------------------
module pcr_config_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Inputs, set at time zero
  logic clk_sys = 1'b0, srst = 1'b1, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0, sample_tick = 1'b0;
  logic playback_source_sel = 1'b1, bitstream_pin_route = 1'b1, play_ready = 1'b0, src_run = 1'b0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, src_word = 8'h00;
  // Outputs and pins
  logic [7:0] cfg_rdata_q, play_data, digital_volume_q;
  logic [1:0] bitstream1_rate_q;
  logic cfg_rvalid_q, bitstream1_clock_pin_in, bitstream1_clock_pin_out, bitstream1_clock_pin_oe, src_clk;
  logic bitstream1_data_pin, play_valid, play_overrun_q, sensor_bit_q, sensor_bit_valid_q, volume_mute_q;
  logic bitstream_volume_active_q, irq_pin_pullup_en_q, spread_spectrum_en_q, switching_sync_en_q;
  logic bitstream1_rate_bad_q;
  int failures = 0, cmp_count = 0;
  logic [7:0] rst_tab [4] = '{8'h00, 8'h06, 8'h00, 8'h08};
  always #5 clk_sys = ~clk_sys;
  // Pin level from whoever drives it
  assign bitstream1_clock_pin_in = bitstream1_clock_pin_oe ? bitstream1_clock_pin_out : src_clk;
  pcr_config_regs i_dut (.*);
  pcr_pdm_source i_src (.run(src_run), .word(src_word), .clk_pin(src_clk), .data_pin(bitstream1_data_pin));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_wr_en = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    cfg_rd_en = 1'b1;
    cfg_addr = a;
    @(negedge clk_sys);
    cfg_rd_en = 1'b0;
    chk("cfg_rdata_q", e, cfg_rdata_q);
  endtask
  task automatic tick();
    @(negedge clk_sys);
    sample_tick = 1'b1;
    @(negedge clk_sys);
    sample_tick = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  // One whole word from the source
  task automatic send(input logic [7:0] w);
    src_word = w;
    src_run = 1'b1;
    #100;
    src_run = 1'b0;
    #1400;
    @(negedge clk_sys);
  endtask
  task automatic pop();
    play_ready = 1'b1;
    @(negedge clk_sys);
    play_ready = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic complete_run();
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100us;
    failures++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    for (int i = 0; i < 4; i++) rd(8'h06 + 8'(i), rst_tab[i]);
    chk("spread", 8'h01, {7'h0, spread_spectrum_en_q});
    chk("vol_active", 8'h01, {7'h0, bitstream_volume_active_q});
    rd(8'h05, 8'h00);
    rd(8'h0A, 8'h00);
    wr(8'h07, 8'h08);
    chk("pullup", 8'h01, {7'h0, irq_pin_pullup_en_q});
    chk("spread", 8'h00, {7'h0, spread_spectrum_en_q});
    wr(8'h08, 8'h44);
    chk("sync", 8'h01, {7'h0, switching_sync_en_q});
    chk("rate", 8'h01, {6'h0, bitstream1_rate_q});
    wr(8'h08, 8'h08);
    chk("rate_bad", 8'h01, {7'h0, bitstream1_rate_bad_q});
    wr(8'h08, 8'h04);
    chk("sync", 8'h00, {7'h0, switching_sync_en_q});
    wr(8'h07, 8'hC0);
    wr(8'h06, 8'hC9);
    chk("volume", 8'hC9, digital_volume_q);
    chk("mute", 8'h01, {7'h0, volume_mute_q});
    wr(8'h07, 8'h00);
    wr(8'h06, 8'hC6);
    for (int i = 1; i <= 3; i++) begin
      tick();
      chk("volume", 8'hC9 - 8'(i), digital_volume_q);
    end
    chk("mute", 8'h00, {7'h0, volume_mute_q});
    wr(8'h07, 8'h40);
    wr(8'h06, 8'hC5);
    repeat (3) tick();
    chk("volume", 8'hC6, digital_volume_q);
    tick();
    chk("volume", 8'hC5, digital_volume_q);
    wr(8'h09, 8'h0A);
    send(8'hA5);
    chk("play_valid", 8'h01, {7'h0, play_valid});
    chk("play_data", 8'hA5, play_data);
    pop();
    wr(8'h09, 8'h8A);
    send(8'h3C);
    chk("play_data", 8'h3C, play_data);
    pop();
    wr(8'h09, 8'h88);
    send(8'h66);
    chk("play_valid", 8'h00, {7'h0, play_valid});
    wr(8'h09, 8'h0A);
    // Two in the buffer, one pending, the fourth replaces the pending one
    repeat (4) send(8'h5A);
    chk("overrun", 8'h01, {7'h0, play_overrun_q});
    chk("play_data", 8'h5A, play_data);
    play_ready = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("play_valid", 8'h00, {7'h0, play_valid});
    bitstream_pin_route = 1'b0;
    playback_source_sel = 1'b0;
    send(8'h01);
    chk("sensor_bit", 8'h01, {7'h0, sensor_bit_q});
    chk("vol_active", 8'h00, {7'h0, bitstream_volume_active_q});
    wr(8'h09, 8'h2A);
    chk("pin_oe", 8'h01, {7'h0, bitstream1_clock_pin_oe});
    complete_run();
  end
endmodule

// *** bench/pcr_pdm_source.sv ***
// ----------------------------------------
// Bitstream source on the clock and data pins
// ----------------------------------------
module pcr_pdm_source (
  // Frame control
  input  wire logic       run,
  input  wire logic [7:0] word,
  // Pins
  output logic            clk_pin,
  output logic            data_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock parks low between words, data churns
  initial begin
    clk_pin = 1'b0;
    data_pin = 1'b0;
    #3;
    forever begin
      if (!run) begin
        clk_pin = 1'b0;
        data_pin = ~data_pin;
        #80;
      end else begin
        // MSB first, 160 ns per bit, stable around both edges
        for (int i = 7; i >= 0; i--) begin
          data_pin = word[i];
          #40;
          clk_pin = 1'b1;
          #80;
          clk_pin = 1'b0;
          #40;
        end
      end
    end
  end
endmodule

// *** rtl/pcr_config_regs.sv ***
// Behaviour
// [RULE1] Volume code steps 0.5 dB, mute above C8h
// [RULE2] Ramp step per 1, 4, 8 samples or none
// [RULE3] Pull-up bit 3 enables interrupt pin pull-up
// [RULE4] Spread spectrum bit 2, enabled after reset
// [RULE5] Sync bit 6 clear leaves switching unsynchronised
// [RULE6] Rate 00b low band, 01b high band
// [RULE7] Edge bit 7 picks rising or falling capture
// [RULE8] Role bit 5 picks slave or master clock
// [RULE9] Select bit 3 picks ground or clock pin
// [RULE10] Gate bit 1 low stops bitstream clock
// [RULE11] Clock register reads 08h after reset
// [RULE12] Misc register reads 06h after reset
// [RULE13] Source bit picks PCM or bitstream playback
// [RULE14] Route bit sends data to sensor or playback
// [RULE15] Applied volume walks one step per interval
module pcr_config_regs (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // Control port
  input  wire logic              cfg_wr_en,
  input  wire logic              cfg_rd_en,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [7:0]        cfg_wdata,
  output logic [7:0]             cfg_rdata_q,
  output logic                   cfg_rvalid_q,
  // Playback selection bits held elsewhere
  input  wire logic              playback_source_sel,
  input  wire logic              bitstream_pin_route,
  // Audio sample strobe
  input  wire logic              sample_tick,
  // Bitstream pins
  input  wire logic              bitstream1_clock_pin_in,
  output logic                   bitstream1_clock_pin_out,
  output logic                   bitstream1_clock_pin_oe,
  input  wire logic              bitstream1_data_pin,
  // Captured playback words
  output logic                   play_valid,
  input  wire logic              play_ready,
  output logic [7:0]             play_data,
  output logic                   play_overrun_q,
  // Sensor path bits
  output logic                   sensor_bit_q,
  output logic                   sensor_bit_valid_q,
  // Volume to the datapath
  output logic [7:0]             digital_volume_q,
  output logic                   volume_mute_q,
  output logic                   bitstream_volume_active_q,
  // Amplifier controls
  output logic                   irq_pin_pullup_en_q,
  output logic                   spread_spectrum_en_q,
  output logic                   switching_sync_en_q,
  output logic [1:0]             bitstream1_rate_q,
  output logic                   bitstream1_rate_bad_q
);
  import pcr_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] pdm_volume_q;            // Bitstream volume code
  logic [7:0] misc_config_q;           // Ramp rate, pull-up, spread spectrum
  logic [7:0] pdm_rate_sync_config_q;  // Sync and bit rate
  logic [7:0] pdm_clock_config_q;      // Edge, role, select, gate

  // Field views
  logic       bitstream1_capture_edge;  // 1 captures on falling edge
  logic       bitstream1_clock_role;    // 1 makes us clock master
  logic       bitstream1_clock_select;  // 0 ties clock to ground
  logic       bitstream1_clock_gate;    // 0 gates clock off
  logic [1:0] volume_ramp_rate;         // Ramp encoding
  logic [1:0] rate_field;               // Raw rate field

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic       clk_pin_meta_q;   // First stage, clock pin
  logic       clk_pin_sync_q;   // Second stage, clock pin
  logic       data_pin_meta_q;  // First stage, data pin
  logic       data_pin_sync_q;  // Second stage, data pin

  // ----------------------------------------------------------------
  // Master clock divider and capture
  // ----------------------------------------------------------------
  logic [4:0] div_cnt_q;        // Half period counter
  logic [4:0] half_period;      // Half period for the rate
  logic       master_clk_q;     // Clock we drive as master
  logic       bit_clk;          // Clock the capture follows
  logic       bit_clk_prev_q;   // Previous clock level
  logic       capture_strobe;   // Capture edge seen
  logic [7:0] shift_q;          // Bits being assembled
  logic [2:0] bit_cnt_q;        // Bits in shift register
  logic       word_valid_q;     // Word offered to buffer
  logic [7:0] word_q;           // Word offered to buffer
  logic       word_done;        // Eighth bit just captured
  logic [7:0] applied_code;     // Ramp output

  pcr_stream_if cap_if ();
  pcr_stream_if play_if ();

  assign bitstream1_capture_edge = pdm_clock_config_q[PCR_EDGE_BIT];
  assign bitstream1_clock_role   = pdm_clock_config_q[PCR_ROLE_BIT];
  assign bitstream1_clock_select = pdm_clock_config_q[PCR_CLKSEL_BIT];
  assign bitstream1_clock_gate   = pdm_clock_config_q[PCR_GATE_BIT];
  assign volume_ramp_rate        = misc_config_q[PCR_RAMP_RATE_LSB +: 2];
  assign rate_field              = pdm_rate_sync_config_q[PCR_RATE_LSB +: 2];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Volume code register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pdm_volume_q <= PCR_RST_PDM_VOLUME;
    end else if (cfg_wr_en && cfg_addr == PCR_ADDR_PDM_VOLUME) begin
      pdm_volume_q <= cfg_wdata;
    end
  end

  // Misc register, reserved bits stored as written
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      misc_config_q <= PCR_RST_MISC_CONFIG;  // see [RULE12] see [RULE4]
    end else if (cfg_wr_en && cfg_addr == PCR_ADDR_MISC_CONFIG) begin
      misc_config_q <= cfg_wdata;
    end
  end

  // Rate and sync register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pdm_rate_sync_config_q <= PCR_RST_PDM_RATE_SYNC;
    end else if (cfg_wr_en && cfg_addr == PCR_ADDR_PDM_RATE_SYNC) begin
      pdm_rate_sync_config_q <= cfg_wdata;
    end
  end

  // Clock setup register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pdm_clock_config_q <= PCR_RST_PDM_CLOCK;  // see [RULE11]
    end else if (cfg_wr_en && cfg_addr == PCR_ADDR_PDM_CLOCK) begin
      pdm_clock_config_q <= cfg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // Read data one cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_rdata_q  <= 8'h00;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_rd_en;
      if (cfg_rd_en) begin
        unique case (cfg_addr)
          PCR_ADDR_PDM_VOLUME:    cfg_rdata_q <= pdm_volume_q;
          PCR_ADDR_MISC_CONFIG:   cfg_rdata_q <= misc_config_q;
          PCR_ADDR_PDM_RATE_SYNC: cfg_rdata_q <= pdm_rate_sync_config_q;
          PCR_ADDR_PDM_CLOCK:     cfg_rdata_q <= pdm_clock_config_q;
          default:                cfg_rdata_q <= 8'h00;  // Unmapped reads zero
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Amplifier control outputs
  // ----------------------------------------------------------------

  // Registered copies of the control bits
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_pin_pullup_en_q   <= 1'b0;
      spread_spectrum_en_q  <= 1'b1;
      switching_sync_en_q   <= 1'b0;
      bitstream1_rate_q     <= 2'b00;
      bitstream1_rate_bad_q <= 1'b0;
    end else begin
      irq_pin_pullup_en_q   <= misc_config_q[PCR_PULLUP_BIT];       // see [RULE3]
      spread_spectrum_en_q  <= misc_config_q[PCR_SPREAD_BIT];       // see [RULE4]
      switching_sync_en_q   <= pdm_rate_sync_config_q[PCR_SYNC_BIT];  // see [RULE5]
      bitstream1_rate_q     <= rate_field;
      bitstream1_rate_bad_q <= rate_field[1];  // see [RULE6]
    end
  end

  // ----------------------------------------------------------------
  // Volume path
  // ----------------------------------------------------------------

  // Ramp engine for the applied volume
  pcr_vol_ramp u_ramp (
    .clk_sys        (clk_sys),
    .srst           (srst),
    .target_code    (pdm_volume_q),
    .ramp_rate      (pcr_ramp_t'(volume_ramp_rate)),
    .sample_tick    (sample_tick),
    .applied_code_q (applied_code)
  );

  // Applied attenuation, mute, and which path it governs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      digital_volume_q          <= 8'h00;
      volume_mute_q             <= 1'b0;
      bitstream_volume_active_q <= 1'b0;
    end else begin
      digital_volume_q          <= applied_code;                   // see [RULE1]
      volume_mute_q             <= (applied_code >= PCR_VOL_MUTE);  // see [RULE1]
      bitstream_volume_active_q <= playback_source_sel;            // see [RULE13]
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  // Two flip-flops per pin before any logic reads them
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clk_pin_meta_q  <= 1'b0;
      clk_pin_sync_q  <= 1'b0;
      data_pin_meta_q <= 1'b0;
      data_pin_sync_q <= 1'b0;
    end else begin
      clk_pin_meta_q  <= bitstream1_clock_pin_in;
      clk_pin_sync_q  <= clk_pin_meta_q;
      data_pin_meta_q <= bitstream1_data_pin;
      data_pin_sync_q <= data_pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Master clock generation
  // ----------------------------------------------------------------

  // Half period from the rate, reserved codes fall back to low band
  assign half_period = (rate_field == 2'b01) ? PCR_HALF_HIGH : PCR_HALF_LOW;  // see [RULE6]

  // Divider runs only as master with clock selected and ungated
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_cnt_q    <= 5'd0;
      master_clk_q <= 1'b0;
    end else if (!(bitstream1_clock_role && bitstream1_clock_select && bitstream1_clock_gate)) begin
      div_cnt_q    <= 5'd0;  // see [RULE8] see [RULE10]
      master_clk_q <= 1'b0;
    end else if (div_cnt_q + 5'd1 >= half_period) begin
      div_cnt_q    <= 5'd0;
      master_clk_q <= ~master_clk_q;
    end else begin
      div_cnt_q    <= div_cnt_q + 5'd1;
    end
  end

  // Pin driven only in master role
  assign bitstream1_clock_pin_out = master_clk_q;
  assign bitstream1_clock_pin_oe  = bitstream1_clock_role && bitstream1_clock_select;  // see [RULE8]

  // ----------------------------------------------------------------
  // Bit capture
  // ----------------------------------------------------------------

  // Clock seen by capture: ground, gated, own or from pin
  always_comb begin
    if (!bitstream1_clock_select || !bitstream1_clock_gate) begin
      bit_clk = 1'b0;  // see [RULE9] see [RULE10]
    end else if (bitstream1_clock_role) begin
      bit_clk = master_clk_q;
    end else begin
      bit_clk = clk_pin_sync_q;
    end
  end

  // Previous clock level for edge finding
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bit_clk_prev_q <= 1'b0;
    end else begin
      bit_clk_prev_q <= bit_clk;
    end
  end

  // Rising or falling edge as configured
  assign capture_strobe = bitstream1_capture_edge ? (bit_clk_prev_q && !bit_clk)
                                                  : (!bit_clk_prev_q && bit_clk);  // see [RULE7]
  assign word_done      = capture_strobe && bitstream_pin_route && bit_cnt_q == PCR_BITS_LAST;

  // Sensor routing of each captured bit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sensor_bit_q       <= 1'b0;
      sensor_bit_valid_q <= 1'b0;
    end else begin
      sensor_bit_valid_q <= capture_strobe && !bitstream_pin_route;  // see [RULE14]
      if (capture_strobe && !bitstream_pin_route) begin
        sensor_bit_q <= data_pin_sync_q;
      end
    end
  end

  // Shift register for the playback route
  always_ff @(posedge clk_sys) begin
    if (srst || !bitstream_pin_route) begin
      shift_q   <= 8'h00;
      bit_cnt_q <= 3'd0;
    end else if (capture_strobe) begin
      shift_q   <= {shift_q[6:0], data_pin_sync_q};  // see [RULE14]
      bit_cnt_q <= bit_cnt_q + 3'd1;
    end
  end

  // Word offered to the buffer until taken
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      word_valid_q   <= 1'b0;
      word_q         <= 8'h00;
      play_overrun_q <= 1'b0;
    end else begin
      if (word_done) begin
        word_valid_q <= 1'b1;
        word_q       <= {shift_q[6:0], data_pin_sync_q};
      end else if (cap_if.ready) begin
        word_valid_q <= 1'b0;
      end
      // Sticky: a new word replaced one the buffer never took
      if (word_done && word_valid_q && !cap_if.ready) begin
        play_overrun_q <= 1'b1;
      end
    end
  end

  assign cap_if.valid = word_valid_q;
  assign cap_if.data  = word_q;

  // ----------------------------------------------------------------
  // Two-entry buffer toward the playback datapath
  // ----------------------------------------------------------------
  pcr_fifo2 u_buf (
    .clk_sys (clk_sys),
    .srst    (srst),
    .fill    (cap_if.sink),
    .drain   (play_if.source)
  );

  assign play_valid    = play_if.valid;
  assign play_data     = play_if.data;
  assign play_if.ready = play_ready;

endmodule

// *** rtl/pcr_fifo2.sv ***
module pcr_fifo2 (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Filling and draining sides
  pcr_stream_if.sink   fill,
  pcr_stream_if.source drain
);
  import pcr_pkg::*;

  logic [7:0] mem_q [2];  // Two entries of storage
  logic       wr_ptr_q;   // Next entry to fill
  logic       rd_ptr_q;   // Next entry to drain
  logic [1:0] count_q;    // Entries held
  logic       push;
  logic       pop;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  assign fill.ready  = (count_q != 2'd2);  // Honest full
  assign drain.valid = (count_q != 2'd0);  // Honest empty
  assign drain.data  = mem_q[rd_ptr_q];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= fill.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'd0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop)  rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + 2'(push) - 2'(pop);
    end
  end

endmodule

// *** rtl/pcr_pkg.sv ***
package pcr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PCR_ADDR_PDM_VOLUME     = 8'h06;  // Bitstream volume code
  localparam logic [7:0] PCR_ADDR_MISC_CONFIG    = 8'h07;  // Ramp, pull-up, spread spectrum
  localparam logic [7:0] PCR_ADDR_PDM_RATE_SYNC  = 8'h08;  // Sync bit and bit rate
  localparam logic [7:0] PCR_ADDR_PDM_CLOCK      = 8'h09;  // Edge, role, select, gate

  // Values after reset
  localparam logic [7:0] PCR_RST_PDM_VOLUME      = 8'h00;
  localparam logic [7:0] PCR_RST_MISC_CONFIG     = 8'h06;
  localparam logic [7:0] PCR_RST_PDM_RATE_SYNC   = 8'h00;
  localparam logic [7:0] PCR_RST_PDM_CLOCK       = 8'h08;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PCR_RAMP_RATE_LSB  = 6;  // Two bits, misc_config
  localparam int PCR_PULLUP_BIT     = 3;  // misc_config
  localparam int PCR_SPREAD_BIT     = 2;  // misc_config
  localparam int PCR_SYNC_BIT       = 6;  // pdm_rate_sync_config
  localparam int PCR_RATE_LSB       = 2;  // Two bits, pdm_rate_sync_config
  localparam int PCR_EDGE_BIT       = 7;  // pdm_clock_config
  localparam int PCR_ROLE_BIT       = 5;  // pdm_clock_config
  localparam int PCR_CLKSEL_BIT     = 3;  // pdm_clock_config
  localparam int PCR_GATE_BIT       = 1;  // pdm_clock_config

  // ----------------------------------------------------------------
  // Volume codes and ramp
  // ----------------------------------------------------------------
  localparam logic [7:0] PCR_VOL_MAX_ATTEN = 8'hC8;  // -100 dB, last audible code
  localparam logic [7:0] PCR_VOL_MUTE      = 8'hC9;  // This code and above mute
  localparam logic [3:0] PCR_RAMP_SAMPLES_1 = 4'h1;
  localparam logic [3:0] PCR_RAMP_SAMPLES_4 = 4'h4;
  localparam logic [3:0] PCR_RAMP_SAMPLES_8 = 4'h8;

  // Ramp rate encodings
  typedef enum logic [1:0] {
    PCR_RAMP_PER1  = 2'b00,
    PCR_RAMP_PER4  = 2'b01,
    PCR_RAMP_PER8  = 2'b10,
    PCR_RAMP_OFF   = 2'b11
  } pcr_ramp_t;

  // ----------------------------------------------------------------
  // Master clock timing at 100 MHz system clock
  // ----------------------------------------------------------------
  localparam int PCR_SYS_CLK_MHZ      = 100;
  localparam int PCR_LOW_RATE_KHZ     = 3125;  // Inside 2.54 to 3.38 MHz
  localparam int PCR_HIGH_RATE_KHZ    = 6250;  // Inside 5.08 to 6.76 MHz
  localparam logic [4:0] PCR_HALF_LOW  = 5'((PCR_SYS_CLK_MHZ * 1000) / (2 * PCR_LOW_RATE_KHZ));
  localparam logic [4:0] PCR_HALF_HIGH = 5'((PCR_SYS_CLK_MHZ * 1000) / (2 * PCR_HIGH_RATE_KHZ));
  localparam logic [2:0] PCR_BITS_LAST = 3'h7;  // Bits per word minus one

endpackage

// *** rtl/pcr_stream_if.sv ***
// Byte stream with valid and ready between capture and buffer
interface pcr_stream_if;
  logic       valid;  // Word offered
  logic       ready;  // Word accepted
  logic [7:0] data;   // Eight bitstream bits, first bit in bit 7

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// *** rtl/pcr_vol_ramp.sv ***
module pcr_vol_ramp
  import pcr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Settings and sample strobe
  input  wire logic [7:0] target_code,
  input  wire pcr_ramp_t  ramp_rate,
  input  wire logic       sample_tick,
  // Applied volume
  output logic [7:0]      applied_code_q
);

  logic [3:0] interval;     // Samples per 0.5 dB step
  logic [3:0] tick_cnt_q;   // Samples since last step

  // Step interval from the ramp rate
  always_comb begin
    unique case (ramp_rate)
      PCR_RAMP_PER1: interval = PCR_RAMP_SAMPLES_1;
      PCR_RAMP_PER4: interval = PCR_RAMP_SAMPLES_4;
      PCR_RAMP_PER8: interval = PCR_RAMP_SAMPLES_8;
      PCR_RAMP_OFF:  interval = PCR_RAMP_SAMPLES_1;
    endcase
  end

  // Sample counter, restarts once the volume has settled
  always_ff @(posedge clk_sys) begin
    if (srst || applied_code_q == target_code) begin
      tick_cnt_q <= 4'h0;
    end else if (sample_tick) begin
      tick_cnt_q <= (tick_cnt_q + 4'h1 >= interval) ? 4'h0 : tick_cnt_q + 4'h1;
    end
  end

  // Applied code walks one code per interval toward the target
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      applied_code_q <= PCR_RST_PDM_VOLUME;
    end else if (ramp_rate == PCR_RAMP_OFF) begin
      applied_code_q <= target_code;  // see [RULE2]
    end else if (sample_tick && tick_cnt_q + 4'h1 >= interval) begin
      if (applied_code_q < target_code) begin
        applied_code_q <= applied_code_q + 8'h01;  // see [RULE15]
      end else if (applied_code_q > target_code) begin
        applied_code_q <= applied_code_q - 8'h01;  // see [RULE2]
      end
    end
  end

endmodule
